// ---- inc/dpsm_consts.vh ----
/*
 * Constants of the drive power state machine: object indexes, control word
 * fields, state codes, status word fields, alarm codes and timing counts.
 * Assumes it is included by bare name and that the clock runs at 40 MHz.
 */
`ifndef DPSM_CONSTS_VH
`define DPSM_CONSTS_VH

// Object indexes of the command and status words.
`define DPSM_IDX_CTRL_WORD 16'h6040
`define DPSM_IDX_STAT_WORD 16'h6041

// Control word bit positions.
`define DPSM_CW_SWITCH_ON 0
`define DPSM_CW_EN_VOLTAGE 1
`define DPSM_CW_QUICK_STOP 2
`define DPSM_CW_EN_OPER 3
`define DPSM_CW_FAULT_RESET 7
`define DPSM_CW_HALT 8
`define DPSM_CW_RESET 16'h0000

// State codes.
`define DPSM_ST_NOT_READY 3'h0
`define DPSM_ST_SW_ON_DIS 3'h1
`define DPSM_ST_READY 3'h2
`define DPSM_ST_SWITCHED_ON 3'h3
`define DPSM_ST_OP_ENABLED 3'h4
`define DPSM_ST_QSTOP 3'h5
`define DPSM_ST_FAULT_REACT 3'h6
`define DPSM_ST_FAULT 3'h7

// Status word bits 6..0 per state, bit 4 left clear and filled from main power.
`define DPSM_SW_NOT_READY 7'h00
`define DPSM_SW_SW_ON_DIS 7'h60
`define DPSM_SW_READY 7'h21
`define DPSM_SW_SWITCHED_ON 7'h23
`define DPSM_SW_OP_ENABLED 7'h27
`define DPSM_SW_QSTOP 7'h07
`define DPSM_SW_FAULT_REACT 7'h2f
`define DPSM_SW_FAULT 7'h28
`define DPSM_SW_VOLT_BIT 4

// Alarm codes.
`define DPSM_ALM_NONE 8'h00
`define DPSM_ALM_NET_BUS 8'h81
`define DPSM_ALM_MAIN_PWR 8'h23

// Quick stop option codes that stop and then disable switch-on.
`define DPSM_QS_OPT_MIN 16'h0001
`define DPSM_QS_OPT_MAX 16'h0003

// Preparation time after operation enabled, in ms, and its cycle count.
`define DPSM_CLK_HZ 40000000
`define DPSM_PREP_MS 250
// Sized to the counter width; equals PREP_MS times the clock cycles per ms.
`define DPSM_PREP_CYCLES 24'h989680
`define DPSM_PREP_W 24

`endif

// ---- src/dpsm_prep_timer.v ----
/*
 * Preparation timer: counts the excitation preparation time after operation
 * enabled is entered and then reports readiness for motion commands.
 * Assumes i_run stays high for as long as operation enabled lasts.
 */
`timescale 1ns/10ps
`include "dpsm_consts.vh"

module dpsm_prep_timer #(
   parameter [`DPSM_PREP_W-1:0] PREP_CYCLES = `DPSM_PREP_CYCLES
) (
   input wire i_clk_sys,
   input wire i_sys_rst,
   input wire i_run,
   output reg o_done
);

   reg [`DPSM_PREP_W-1:0] cnt_ff;

   // Count while running; restart from zero each time the state is left.
   always @(posedge i_clk_sys) begin
      if (i_sys_rst || !i_run) begin
         cnt_ff <= {`DPSM_PREP_W{1'b0}};
         o_done <= 1'b0;
      end else if (cnt_ff < PREP_CYCLES - 1'b1) begin
         cnt_ff <= cnt_ff + 1'b1;
      end else begin
         o_done <= 1'b1;
      end
   end

endmodule

// ---- src/dpsm_top.v ----
/*
 * Drive power state machine: decodes the control word written by the
 * fieldbus master, steps through the eight drive states, drives motor
 * excitation, the status word and alarm codes.
 * Assumes all inputs are synchronous to i_clk_sys and that the master holds
 * the control word until its effect shows in the status word.
 */
// Functional notes
// - Start not-ready, initialize, then switch-on-disabled
// - Excite only in enabled, quick stop, reaction
// - Wait 250 ms then raise command ready
// - Control word field positions as fixed
// - Decode shutdown, switch on, enable, stop, reset
// - Ready plus 1111 goes straight to enabled
// - Switch on needs bus, power, no free-run
// - Quick stop option 1..3: stop, disable
// - Alarm: fault reaction, stop, then fault
// - Stopped: bus, power or free-run lost to ready
// - Moving bus loss raises alarm 81h
// - Moving power loss raises alarm 23h
// - Moving free-run enters ready, no alarm
// - Quick stop conditions lead to switch-on-disabled
// - Status bits 6..0 encode state, bit 4 power
`timescale 1ns/10ps
`include "dpsm_consts.vh"

module dpsm_top #(
   parameter [`DPSM_PREP_W-1:0] PREP_CYCLES = `DPSM_PREP_CYCLES
) (
   input wire i_clk_sys,
   input wire i_sys_rst,
   input wire i_ctrl_wr,
   input wire [15:0] i_ctrl_word,
   input wire [15:0] i_qs_option,
   input wire i_init_done,
   input wire i_bus_operational,
   input wire i_main_power,
   input wire i_free_run,
   input wire i_remote_test,
   input wire i_motor_moving,
   input wire i_stop_done,
   input wire i_alarm,
   input wire [7:0] i_alarm_code,
   input wire i_motion_cmd,
   output reg [15:0] o_ctrl_word,
   output reg [15:0] o_status_word,
   output reg [2:0] o_state,
   output reg o_motor_excite,
   output reg o_param_write_ok,
   output reg o_motion_command_ready_output,
   output reg o_motion_cmd_accept,
   output reg o_alarm_active,
   output reg [7:0] o_alarm_code
);

   reg [15:0] ctrl_ff;
   reg fr_prev_ff;
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [7:0] alarm_ff;
   reg [7:0] nxt_alarm;
   reg [6:0] stat_code;
   wire prep_done;
   wire [3:0] cmd;
   wire fault_reset_rise;
   wire conds_ok;
   wire lost_cond;
   wire qs_opt_ok;

   // Status code for a state, bit 4 filled from main power separately.
   function [6:0] dpsm_stat_of;
      input [2:0] st;
      begin
         case (st)
            `DPSM_ST_SW_ON_DIS: dpsm_stat_of = `DPSM_SW_SW_ON_DIS;
            `DPSM_ST_READY: dpsm_stat_of = `DPSM_SW_READY;
            `DPSM_ST_SWITCHED_ON: dpsm_stat_of = `DPSM_SW_SWITCHED_ON;
            `DPSM_ST_OP_ENABLED: dpsm_stat_of = `DPSM_SW_OP_ENABLED;
            `DPSM_ST_QSTOP: dpsm_stat_of = `DPSM_SW_QSTOP;
            `DPSM_ST_FAULT_REACT: dpsm_stat_of = `DPSM_SW_FAULT_REACT;
            `DPSM_ST_FAULT: dpsm_stat_of = `DPSM_SW_FAULT;
            default: dpsm_stat_of = `DPSM_SW_NOT_READY;
         endcase
      end
   endfunction

   // Control word register; a write lands here and is decoded next cycle.
   always @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         ctrl_ff <= `DPSM_CW_RESET;
         fr_prev_ff <= 1'b0;
      end else begin
         if (i_ctrl_wr) begin
            ctrl_ff <= i_ctrl_word;
         end
         fr_prev_ff <= ctrl_ff[`DPSM_CW_FAULT_RESET];
      end
   end

   // Command field and derived conditions.
   assign cmd = {ctrl_ff[`DPSM_CW_EN_OPER], ctrl_ff[`DPSM_CW_QUICK_STOP],
                 ctrl_ff[`DPSM_CW_EN_VOLTAGE], ctrl_ff[`DPSM_CW_SWITCH_ON]};
   assign fault_reset_rise = ctrl_ff[`DPSM_CW_FAULT_RESET] && !fr_prev_ff;
   assign conds_ok = i_bus_operational && i_main_power && !i_free_run &&
                     !i_remote_test;
   assign lost_cond = !i_bus_operational || !i_main_power || i_free_run;
   assign qs_opt_ok = (i_qs_option >= `DPSM_QS_OPT_MIN) &&
                      (i_qs_option <= `DPSM_QS_OPT_MAX);

   // Next state. Alarms take priority, then link events, then commands.
   // Patterns with no transition from the present state fall through to hold.
   always @* begin
      nxt_state = state_ff;
      nxt_alarm = alarm_ff;
      case (state_ff)
         `DPSM_ST_NOT_READY: begin
            if (i_init_done) begin
               nxt_state = `DPSM_ST_SW_ON_DIS;
            end
         end
         `DPSM_ST_SW_ON_DIS: begin
            if (i_alarm) begin
               nxt_state = `DPSM_ST_FAULT_REACT;
               nxt_alarm = i_alarm_code;
            end else if (cmd[2:1] == 2'b11 && !cmd[0]) begin
               nxt_state = `DPSM_ST_READY;
            end
         end
         `DPSM_ST_READY: begin
            if (i_alarm) begin
               nxt_state = `DPSM_ST_FAULT_REACT;
               nxt_alarm = i_alarm_code;
            end else if (!cmd[1] || !cmd[2]) begin
               nxt_state = `DPSM_ST_SW_ON_DIS;
            end else if (cmd == 4'hf && conds_ok) begin
               nxt_state = `DPSM_ST_OP_ENABLED;
            end else if (cmd == 4'h7 && conds_ok) begin
               nxt_state = `DPSM_ST_SWITCHED_ON;
            end
         end
         `DPSM_ST_SWITCHED_ON: begin
            if (i_alarm) begin
               nxt_state = `DPSM_ST_FAULT_REACT;
               nxt_alarm = i_alarm_code;
            end else if (lost_cond) begin
               nxt_state = `DPSM_ST_READY;
            end else if (!cmd[1] || !cmd[2]) begin
               nxt_state = `DPSM_ST_SW_ON_DIS;
            end else if (!cmd[0]) begin
               nxt_state = `DPSM_ST_READY;
            end else if (cmd[3]) begin
               nxt_state = `DPSM_ST_OP_ENABLED;
            end
         end
         `DPSM_ST_OP_ENABLED: begin
            if (i_alarm) begin
               nxt_state = `DPSM_ST_FAULT_REACT;
               nxt_alarm = i_alarm_code;
            end else if (i_motor_moving && !i_bus_operational) begin
               nxt_state = `DPSM_ST_FAULT_REACT;
               nxt_alarm = `DPSM_ALM_NET_BUS;
            end else if (i_motor_moving && !i_main_power) begin
               nxt_state = `DPSM_ST_FAULT_REACT;
               nxt_alarm = `DPSM_ALM_MAIN_PWR;
            end else if (lost_cond) begin
               nxt_state = `DPSM_ST_READY;
            end else if (!cmd[1]) begin
               nxt_state = `DPSM_ST_SW_ON_DIS;
            end else if (!cmd[2]) begin
               nxt_state = `DPSM_ST_QSTOP;
            end else if (!cmd[0]) begin
               nxt_state = `DPSM_ST_READY;
            end else if (!cmd[3]) begin
               nxt_state = `DPSM_ST_SWITCHED_ON;
            end
         end
         `DPSM_ST_QSTOP: begin
            if (i_alarm) begin
               nxt_state = `DPSM_ST_FAULT_REACT;
               nxt_alarm = i_alarm_code;
            end else if (i_motor_moving && !i_bus_operational) begin
               nxt_state = `DPSM_ST_FAULT_REACT;
               nxt_alarm = `DPSM_ALM_NET_BUS;
            end else if (i_motor_moving && !i_main_power) begin
               nxt_state = `DPSM_ST_FAULT_REACT;
               nxt_alarm = `DPSM_ALM_MAIN_PWR;
            end else if (lost_cond) begin
               nxt_state = `DPSM_ST_SW_ON_DIS;
            end else if (!cmd[1]) begin
               nxt_state = `DPSM_ST_SW_ON_DIS;
            end else if (qs_opt_ok && i_stop_done) begin
               nxt_state = `DPSM_ST_SW_ON_DIS;
            end else if (!qs_opt_ok && cmd == 4'hf) begin
               nxt_state = `DPSM_ST_OP_ENABLED;
            end
         end
         `DPSM_ST_FAULT_REACT: begin
            if (i_stop_done) begin
               nxt_state = `DPSM_ST_FAULT;
            end
         end
         `DPSM_ST_FAULT: begin
            if (fault_reset_rise && !i_alarm) begin
               nxt_state = `DPSM_ST_SW_ON_DIS;
               nxt_alarm = `DPSM_ALM_NONE;
            end
         end
         default: nxt_state = `DPSM_ST_NOT_READY;
      endcase
   end

   // State and alarm registers.
   always @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         state_ff <= `DPSM_ST_NOT_READY;
         alarm_ff <= `DPSM_ALM_NONE;
      end else begin
         state_ff <= nxt_state;
         alarm_ff <= nxt_alarm;
      end
   end

   // Excitation preparation runs only while operation enabled is held.
   dpsm_prep_timer #(
      .PREP_CYCLES(PREP_CYCLES)
   ) u_prep (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_run(state_ff == `DPSM_ST_OP_ENABLED),
      .o_done(prep_done)
   );

   always @* begin
      stat_code = dpsm_stat_of(state_ff);
   end

   // Registered outputs. The status lags the state by one cycle, which keeps
   // every output straight from a flip-flop at the cost of that cycle.
   always @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_ctrl_word <= `DPSM_CW_RESET;
         o_status_word <= 16'h0000;
         o_state <= `DPSM_ST_NOT_READY;
         o_motor_excite <= 1'b0;
         o_param_write_ok <= 1'b0;
         o_motion_command_ready_output <= 1'b0;
         o_motion_cmd_accept <= 1'b0;
         o_alarm_active <= 1'b0;
         o_alarm_code <= `DPSM_ALM_NONE;
      end else begin
         o_ctrl_word <= ctrl_ff;
         o_status_word <= {9'h000, stat_code[6:5],
                           i_main_power && state_ff != `DPSM_ST_NOT_READY,
                           stat_code[3:0]};
         o_state <= state_ff;
         o_motor_excite <= (state_ff == `DPSM_ST_OP_ENABLED) ||
                           (state_ff == `DPSM_ST_QSTOP) ||
                           (state_ff == `DPSM_ST_FAULT_REACT);
         o_param_write_ok <= (state_ff != `DPSM_ST_NOT_READY);
         o_motion_command_ready_output <= prep_done &&
                                          state_ff == `DPSM_ST_OP_ENABLED;
         o_motion_cmd_accept <= i_motion_cmd && prep_done &&
                                state_ff == `DPSM_ST_OP_ENABLED &&
                                !ctrl_ff[`DPSM_CW_HALT];
         o_alarm_active <= (alarm_ff != `DPSM_ALM_NONE);
         o_alarm_code <= alarm_ff;
      end
   end

endmodule

// ---- verification/dpsm_monitor.sv ----
/* Checker of dpsm_top port behaviour, bound to every dpsm_top.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/10ps
module dpsm_monitor (
   input wire i_clk_sys,
   input wire i_sys_rst,
   input wire i_bus_operational,
   input wire i_main_power,
   input wire i_free_run,
   input wire i_remote_test,
   input wire [15:0] o_status_word,
   input wire [2:0] o_state,
   input wire o_motor_excite,
   input wire o_param_write_ok,
   input wire o_motion_command_ready_output,
   input wire o_motion_cmd_accept,
   input wire o_alarm_active,
   input wire [7:0] o_alarm_code
);
   // Status bits 6..0 by state code; bit 4 is masked since it follows power.
   localparam [55:0] SWT = {7'h28, 7'h2f, 7'h07, 7'h27, 7'h23, 7'h21, 7'h60, 7'h00};
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   excite_map_a: assert property (o_motor_excite == (o_state inside {3'h4, 3'h5, 3'h6}))
      else $error("excitation does not match state");
   param_ok_a: assert property (o_param_write_ok == (o_state != 3'h0))
      else $error("parameter write enable wrong");
   status_code_a: assert property (
      (o_status_word & 16'hffef) == {9'h000, SWT[o_state*7 +: 7]})
      else $error("status word does not match state");
   prep_wait_a: assert property (
      $rose(o_state == 3'h4) |-> !o_motion_command_ready_output [*8])
      else $error("ready output too early");
   accept_state_a: assert property (o_motion_cmd_accept |-> o_state == 3'h4)
      else $error("motion accepted outside enabled state");
   init_exit_a: assert property (
      $past(o_state) == 3'h0 && o_state != 3'h0 |-> o_state == 3'h1)
      else $error("not-ready left to wrong state");
   fault_entry_a: assert property (
      o_state == 3'h7 && $past(o_state) != 3'h7 |-> $past(o_state) == 3'h6)
      else $error("fault entered without fault reaction");
   fault_exit_a: assert property (
      $past(o_state) == 3'h7 && o_state != 3'h7 && o_state != 3'h0 |-> o_state == 3'h1)
      else $error("fault left to wrong state");
   ready_gate_a: assert property (
      $past(o_state) == 3'h2 && o_state inside {3'h3, 3'h4}
      |-> $past(i_bus_operational && i_main_power && !i_free_run && !i_remote_test, 2))
      else $error("switch on taken while refused");
   alarm_flag_a: assert property (o_alarm_active == (o_alarm_code != 8'h00))
      else $error("alarm flag and code disagree");
endmodule
bind dpsm_top dpsm_monitor u_mon (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
   .i_bus_operational(i_bus_operational), .i_main_power(i_main_power),
   .i_free_run(i_free_run), .i_remote_test(i_remote_test), .o_status_word(o_status_word),
   .o_state(o_state), .o_motor_excite(o_motor_excite), .o_param_write_ok(o_param_write_ok),
   .o_motion_command_ready_output(o_motion_command_ready_output),
   .o_motion_cmd_accept(o_motion_cmd_accept), .o_alarm_active(o_alarm_active),
   .o_alarm_code(o_alarm_code));

// ---- verification/dpsm_master.sv ----
/* Fieldbus master model: writes control words and requests motion.
   Assumes the bench calls its tasks from one process only. */
`timescale 1ns/10ps
module dpsm_master (
   input wire i_clk_sys,
   input wire i_accept,
   output reg o_ctrl_wr = 1'b0,
   output reg [15:0] o_ctrl_word = 16'h0000,
   output reg o_motion_cmd = 1'b0
);
   // One strobe per word; the word is held so the state keeps seeing it.
   task send(input [15:0] w);
      begin
         @(posedge i_clk_sys);
         #2;
         o_ctrl_word = w;
         o_ctrl_wr = 1'b1;
         @(posedge i_clk_sys);
         #2;
         o_ctrl_wr = 1'b0;
      end
   endtask
   // One-cycle motion request; an early one is only sent when the bench asks.
   task motion(output reg seen);
      integer n;
      begin
         seen = 1'b0;
         @(posedge i_clk_sys);
         #2;
         o_motion_cmd = 1'b1;
         for (n = 0; n < 4; n = n + 1) begin
            @(posedge i_clk_sys);
            #2;
            o_motion_cmd = 1'b0;
            if (i_accept === 1'b1) seen = 1'b1;
         end
      end
   endtask
endmodule

// ---- verification/drive_power_state_machine_test.sv ----
/* Self-checking bench of dpsm_top with the master model.
   Assumes a short preparation count so the run stays brief. */
`timescale 1ns/10ps
module drive_power_state_machine_test;
   reg clk = 1'b0, rst = 1'b1, init_done = 1'b0, bus_op = 1'b1, power = 1'b1;
   reg free_run = 1'b0, rtest = 1'b0, moving = 1'b0, stop_done = 1'b0, alarm = 1'b0;
   reg [7:0] alm_in = 8'h00;
   reg [15:0] qs_opt = 16'h0005;
   reg seen;
   integer fail_count = 0, samples_checked = 0, i;
   wire wr, mcmd, excite, wr_ok, ready, accept, alm_act;
   wire [15:0] word, rb, status;
   wire [2:0] state;
   wire [7:0] alm_code;
   dpsm_master u_master (.i_clk_sys(clk), .i_accept(accept), .o_ctrl_wr(wr),
      .o_ctrl_word(word), .o_motion_cmd(mcmd));
   dpsm_top #(.PREP_CYCLES(24'h000014)) DUT (.i_clk_sys(clk), .i_sys_rst(rst),
      .i_ctrl_wr(wr), .i_ctrl_word(word), .i_qs_option(qs_opt), .i_init_done(init_done),
      .i_bus_operational(bus_op), .i_main_power(power), .i_free_run(free_run),
      .i_remote_test(rtest), .i_motor_moving(moving), .i_stop_done(stop_done),
      .i_alarm(alarm), .i_alarm_code(alm_in), .i_motion_cmd(mcmd), .o_ctrl_word(rb),
      .o_status_word(status), .o_state(state), .o_motor_excite(excite),
      .o_param_write_ok(wr_ok), .o_motion_command_ready_output(ready),
      .o_motion_cmd_accept(accept), .o_alarm_active(alm_act), .o_alarm_code(alm_code));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task chk(input [15:0] got, input [15:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task tick(input integer n);
      integer k;
      for (k = 0; k < n; k = k + 1) @(posedge clk) #2;
   endtask
   // Bounded wait; running out of cycles shows up as a mismatch.
   task wait_st(input [2:0] s);
      integer n;
      begin
         for (n = 0; n < 8 && state !== s; n = n + 1) tick(1);
         chk({13'h0000, state}, {13'h0000, s});
      end
   endtask
   task go(input [15:0] w, input [2:0] s);
      begin
         u_master.send(w);
         wait_st(s);
      end
   endtask
   task t_init;
      begin
         tick(3);
         chk(wr_ok, 1'b0);
         init_done = 1'b1;
         wait_st(3'h1);
         chk(status, 16'h0070);
      end
   endtask
   task t_enable;
      begin
         go(16'h0006, 3'h2);
         chk(status, 16'h0031);
         go(16'h000f, 3'h4);
         chk(excite, 1'b1);
         chk(rb, 16'h000f);
         u_master.motion(seen);
         chk(seen, 1'b0);
         for (i = 0; i < 40 && ready !== 1'b1; i = i + 1) tick(1);
         chk(ready, 1'b1);
         // Five cycles went to the early request, so the sum is the preparation count.
         chk(i[15:0] + 16'h0005, 16'h0014);
         u_master.motion(seen);
         chk(seen, 1'b1);
         u_master.send(16'h010f);
         u_master.motion(seen);
         chk(seen, 1'b0);
         go(16'h0007, 3'h3);
         chk(excite, 1'b0);
         go(16'h0000, 3'h1);
      end
   endtask
   task t_refuse;
      for (i = 0; i < 4; i = i + 1) begin
         go(16'h0006, 3'h2);
         {bus_op, power, free_run, rtest} = 4'hc ^ (4'h8 >> i);
         u_master.send(16'h000f);
         tick(4);
         chk(state, 3'h2);
         {bus_op, power, free_run, rtest} = 4'hc;
         // The held word is taken as soon as every condition is back.
         wait_st(3'h4);
      end
   endtask
   task t_qstop;
      begin
         go(16'h000f, 3'h4);
         go(16'h000b, 3'h5);
         stop_done = 1'b1;
         tick(4);
         chk(state, 3'h5);
         go(16'h000f, 3'h4);
         qs_opt = 16'h0002;
         go(16'h000b, 3'h1);
         stop_done = 1'b0;
      end
   endtask
   task t_alarm;
      for (i = 0; i < 3; i = i + 1) begin
         go(16'h0006, 3'h2);
         go(16'h000f, 3'h4);
         moving = 1'b1;
         // Bus loss, then power loss, then an outside alarm with its own code.
         {bus_op, power, alarm, alm_in} = (i == 0) ? 11'h200 : (i == 1) ? 11'h400 : 11'h742;
         wait_st(3'h6);
         chk(alm_code, (i == 0) ? 8'h81 : (i == 1) ? 8'h23 : 8'h42);
         stop_done = 1'b1;
         wait_st(3'h7);
         chk(excite, 1'b0);
         {bus_op, power, alarm, alm_in, moving, stop_done} = 13'h1800;
         u_master.send(16'h000f);
         tick(4);
         chk(state, 3'h7);
         go(16'h0080, 3'h1);
         chk(alm_act, 1'b0);
      end
   endtask
   task t_loss;
      begin
         go(16'h0006, 3'h2);
         go(16'h000f, 3'h4);
         moving = 1'b1;
         free_run = 1'b1;
         wait_st(3'h2);
         chk(alm_act, 1'b0);
         {free_run, moving, qs_opt} = 18'h00005;
         go(16'h000f, 3'h4);
         power = 1'b0;
         wait_st(3'h2);
         power = 1'b1;
         go(16'h000f, 3'h4);
         go(16'h000b, 3'h5);
         {moving, free_run} = 2'h3;
         wait_st(3'h1);
         {moving, free_run} = 2'h0;
      end
   endtask
   task print_verdict;
      begin
         if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   initial begin
      tick(2);
      rst = 1'b0;
      t_init;
      t_enable;
      t_refuse;
      t_qstop;
      t_alarm;
      t_loss;
      print_verdict;
   end
endmodule
